//--- eacsd_defines.vh
`ifndef EACSD_DEFINES_VH
`define EACSD_DEFINES_VH

// ********************************************************************
// Register map, 5-bit word index on the register port.
// ********************************************************************
`define EACSD_AREA_BASE_OFS 2'h0
`define EACSD_AREA_MASK_OFS 2'h1
`define EACSD_AREA_CTRL_OFS 2'h2
`define EACSD_FALLBACK_CTRL_ADDR 5'h10
`define EACSD_PAGE_ROM_ADDR 5'h11
`define EACSD_STATUS_ADDR 5'h12

// ********************************************************************
// Area control word fields.
// ********************************************************************
`define EACSD_WR_WAIT_LSB 0
`define EACSD_RD_WAIT_LSB 4
`define EACSD_WIDTH_LSB 8
`define EACSD_MEM_TYPE_LSB 12
`define EACSD_DECODE_SEL_BIT 14
`define EACSD_ENABLE_BIT 15

// ********************************************************************
// Encodings and reset values.
// ********************************************************************
`define EACSD_WIDTH_8 2'h0
`define EACSD_WIDTH_16 2'h1
`define EACSD_WIDTH_32 2'h2
`define EACSD_WAIT_EXTERNAL 3'h4
`define EACSD_CTRL_RESET 16'h0000
`define EACSD_AREA2_CTRL_RESET 16'h8000
`define EACSD_BASE_RESET 8'h00
`define EACSD_MASK_RESET 16'h0000
`define EACSD_PAGE_ROM_RESET 3'h0
`define EACSD_PAGE_ENABLE_BIT 0

`endif

//--- eacsd_memory_controller.v
// The plain strobed port and the register offsets were chosen for this implementation.
`default_nettype none
`include "eacsd_defines.vh"

module eacsd_memory_controller (
  // Clock, reset and clock enable.
  input wire i_clk,
  input wire i_reset_n,
  input wire i_ce,
  // Register port.
  input wire [4:0] i_reg_addr,
  input wire [15:0] i_reg_wdata,
  input wire i_reg_wr,
  input wire i_reg_rd,
  output reg [15:0] o_reg_rdata,
  // Boot strap pins.
  input wire [1:0] i_boot_width_pins,
  // Internal processor bus.
  input wire i_bus_req,
  input wire i_bus_write,
  input wire [23:0] i_bus_addr,
  input wire i_int_io_hit,
  input wire i_int_mem_hit,
  output wire o_bus_ready,
  output reg [1:0] o_bus_width,
  // External memory side.
  input wire i_wait_n,
  output reg [3:0] o_area_select_n,
  output reg o_fallback_select_n,
  output reg o_rd_n,
  output reg o_wr_n
);

  // ******************************************************************
  // States.
  // ******************************************************************
  localparam [2:0] S_IDLE = 3'b001;
  localparam [2:0] S_STROBE = 3'b010;
  localparam [2:0] S_XWAIT = 3'b100;

  // ******************************************************************
  // Configuration registers.
  // ******************************************************************
  reg [7:0] base_reg [0:3];
  reg [15:0] mask_reg [0:3];
  reg [15:0] ctrl_reg [0:3];
  reg [15:0] fallback_ctrl_reg;
  reg [2:0] page_rom_reg;
  reg boot_pending_reg;
  reg [1:0] boot_width_reg;

  // ******************************************************************
  // Bus cycle state.
  // ******************************************************************
  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg [1:0] wait_cnt_reg;
  reg ext_wait_reg;
  reg [23:0] last_rd_addr_reg;
  reg [4:0] last_rd_sel_reg;
  reg last_rd_valid_reg;

  wire [1:0] area_idx;
  wire [1:0] area_field;
  wire area_space;
  wire [3:0] area_match;

  // Index bit 4 clear selects the area space, bits 3..2 the area, bits 1..0 the register.
  assign area_idx = i_reg_addr[3:2];
  assign area_field = i_reg_addr[1:0];
  assign area_space = ~i_reg_addr[4];

  // ******************************************************************
  // Address decode per area.
  // ******************************************************************
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_area
      wire [23:0] base_full;
      wire [23:0] ignore_full;
      wire enabled;
      wire full_space;
      // Bases sit on 64 Kbyte steps, so the low sixteen address bits are zero.
      assign base_full = {base_reg[g], 16'h0000};
      if (g == 0) begin : g_a0
        // Mask bits 12..0 cover A20..A8; the low byte is never compared.
        assign ignore_full = {3'h0, mask_reg[g][12:0], 8'hff};
      end else if (g == 1) begin : g_a1
        // One mask bit stands for the whole A15..A9 group in this area.
        assign ignore_full = {2'h0, mask_reg[g][7:2], {7{mask_reg[g][1]}},
          mask_reg[g][0], 8'hff};
      end else begin : g_a23
        // Mask bits 7..0 cover A22..A15; A23 is always compared.
        assign ignore_full = {1'b0, mask_reg[g][7:0], 15'h7fff};
      end
      assign enabled = ctrl_reg[g][`EACSD_ENABLE_BIT];
      // Area 2 alone may span the whole space, as it does straight after reset.
      assign full_space = (g == 2) && !ctrl_reg[g][`EACSD_DECODE_SEL_BIT];
      assign area_match[g] = enabled && (full_space ||
        (((i_bus_addr ^ base_full) & ~ignore_full) == 24'h000000));
    end
  endgenerate

  // ******************************************************************
  // Priority selection of the area for the current request.
  // ******************************************************************
  reg [4:0] sel;
  reg [15:0] sel_ctrl;
  reg [2:0] sel_wait;
  reg page_hit;
  reg page_same;
  always @* begin
    sel = 5'h00;
    if (i_int_io_hit || i_int_mem_hit) begin
      sel = 5'h00;
    end else if (area_match[0]) begin
      sel = 5'h01;
    end else if (area_match[1]) begin
      sel = 5'h02;
    end else if (area_match[2]) begin
      sel = 5'h04;
    end else if (area_match[3]) begin
      sel = 5'h08;
    end else begin
      sel = 5'h10;
    end
    case (sel)
      5'h01: sel_ctrl = ctrl_reg[0];
      5'h02: sel_ctrl = ctrl_reg[1];
      5'h04: sel_ctrl = ctrl_reg[2];
      5'h08: sel_ctrl = ctrl_reg[3];
      default: sel_ctrl = fallback_ctrl_reg;
    endcase
    if (i_bus_write) begin
      sel_wait = sel_ctrl[`EACSD_WR_WAIT_LSB +: 3];
    end else begin
      sel_wait = sel_ctrl[`EACSD_RD_WAIT_LSB +: 3];
    end
    // A reserved page size never hits, so such reads keep their full wait count.
    page_same = 1'b0;
    case (page_rom_reg[2:1])
      2'h0: page_same = (last_rd_addr_reg[23:2] == i_bus_addr[23:2]);
      2'h1: page_same = (last_rd_addr_reg[23:3] == i_bus_addr[23:3]);
      2'h2: page_same = (last_rd_addr_reg[23:4] == i_bus_addr[23:4]);
      default: page_same = 1'b0;
    endcase
    page_hit = page_rom_reg[`EACSD_PAGE_ENABLE_BIT] && !i_bus_write &&
      last_rd_valid_reg && (last_rd_sel_reg == sel) && page_same;
  end

  wire start;
  wire finish;
  wire fixed_done;
  wire ext_done;
  assign start = (state_reg == S_IDLE) && i_bus_req && (sel != 5'h00);
  // A fixed count ends once it has run out; the external line can hold it only in external wait mode.
  assign fixed_done = (state_reg == S_STROBE) && (wait_cnt_reg == 2'h0) &&
    !(ext_wait_reg && !i_wait_n);
  assign ext_done = (state_reg == S_XWAIT) && i_wait_n;
  assign finish = fixed_done || ext_done;
  // Ready is held back while the clock enable is low: the sequencer stands
  // still then, and the bus must not see the same end of access twice.
  assign o_bus_ready = finish && i_ce;

  // ******************************************************************
  // Wait count loaded when an access starts.
  // ******************************************************************
  reg [1:0] wait_load;
  reg ext_load;
  always @* begin
    wait_load = 2'h0;
    ext_load = 1'b0;
    if (page_hit) begin
      wait_load = 2'h0;
    end else if (sel_wait >= `EACSD_WAIT_EXTERNAL) begin
      ext_load = 1'b1;
    end else begin
      wait_load = sel_wait[1:0];
    end
  end

  // ******************************************************************
  // Bus cycle sequencer.
  // ******************************************************************
  always @* begin
    state_next = state_reg;
    case (state_reg)
      S_IDLE: begin
        if (start) begin
          state_next = S_STROBE;
        end
      end
      S_STROBE: begin
        // Out of fixed waits with the external line low: go to S_XWAIT until it rises.
        if (finish) begin
          state_next = S_IDLE;
        end else if (wait_cnt_reg == 2'h0) begin
          state_next = S_XWAIT;
        end
      end
      S_XWAIT: begin
        if (finish) begin
          state_next = S_IDLE;
        end
      end
      default: begin
        state_next = S_IDLE;
      end
    endcase
  end

  // ******************************************************************
  // Bus outputs and wait counter.
  // ******************************************************************
  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_reg <= S_IDLE;
      wait_cnt_reg <= 2'h0;
      ext_wait_reg <= 1'b0;
      o_area_select_n <= 4'hf;
      o_fallback_select_n <= 1'b1;
      o_rd_n <= 1'b1;
      o_wr_n <= 1'b1;
      o_bus_width <= `EACSD_WIDTH_8;
      last_rd_addr_reg <= 24'h000000;
      last_rd_sel_reg <= 5'h00;
      last_rd_valid_reg <= 1'b0;
    end else if (i_ce) begin
      state_reg <= state_next;
      if (start) begin
        // Selects and strobes fall together here and rise together at the end.
        o_area_select_n <= ~sel[3:0];
        o_fallback_select_n <= ~sel[4];
        o_rd_n <= i_bus_write;
        o_wr_n <= ~i_bus_write;
        o_bus_width <= sel_ctrl[`EACSD_WIDTH_LSB +: 2];
        wait_cnt_reg <= wait_load;
        ext_wait_reg <= ext_load;
        if (!i_bus_write) begin
          last_rd_addr_reg <= i_bus_addr;
          last_rd_sel_reg <= sel;
          last_rd_valid_reg <= 1'b1;
        end
      end else if (state_reg == S_STROBE && wait_cnt_reg != 2'h0) begin
        wait_cnt_reg <= wait_cnt_reg - 2'h1;
      end
      if (finish) begin
        o_area_select_n <= 4'hf;
        o_fallback_select_n <= 1'b1;
        o_rd_n <= 1'b1;
        o_wr_n <= 1'b1;
      end
      // A register write may move an area or its page size, so the page memory is dropped.
      if (i_reg_wr) begin
        last_rd_valid_reg <= 1'b0;
      end
    end
  end

  // ******************************************************************
  // Register writes and boot width capture.
  // ******************************************************************
  wire hit_fallback;
  wire hit_page_rom;
  wire hit_status;
  assign hit_fallback = (i_reg_addr == `EACSD_FALLBACK_CTRL_ADDR);
  assign hit_page_rom = (i_reg_addr == `EACSD_PAGE_ROM_ADDR);
  assign hit_status = (i_reg_addr == `EACSD_STATUS_ADDR);

  integer k;
  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      for (k = 0; k < 4; k = k + 1) begin
        base_reg[k] <= `EACSD_BASE_RESET;
        mask_reg[k] <= `EACSD_MASK_RESET;
        ctrl_reg[k] <= `EACSD_CTRL_RESET;
      end
      // Only area 2 comes out of reset enabled, spanning the whole space.
      ctrl_reg[2] <= `EACSD_AREA2_CTRL_RESET;
      fallback_ctrl_reg <= `EACSD_CTRL_RESET;
      page_rom_reg <= `EACSD_PAGE_ROM_RESET;
      boot_pending_reg <= 1'b1;
      boot_width_reg <= `EACSD_WIDTH_8;
    end else if (i_ce) begin
      // The straps count only at the first enabled edge; later pin changes are ignored.
      if (boot_pending_reg) begin
        boot_pending_reg <= 1'b0;
        boot_width_reg <= i_boot_width_pins;
        ctrl_reg[2][`EACSD_WIDTH_LSB +: 2] <= i_boot_width_pins;
      end
      if (i_reg_wr) begin
        if (area_space) begin
          case (area_field)
            `EACSD_AREA_BASE_OFS: base_reg[area_idx] <= i_reg_wdata[7:0];
            `EACSD_AREA_MASK_OFS: mask_reg[area_idx] <= i_reg_wdata;
            `EACSD_AREA_CTRL_OFS: ctrl_reg[area_idx] <= i_reg_wdata;
            default: begin
            end
          endcase
        end else if (hit_fallback) begin
          fallback_ctrl_reg <= i_reg_wdata;
        end else if (hit_page_rom) begin
          page_rom_reg <= i_reg_wdata[2:0];
        end
      end
    end
  end

  // ******************************************************************
  // Register read data, valid in the cycle after the read strobe.
  // ******************************************************************
  reg [15:0] rd_value;
  wire [15:0] status_word;
  // Status layout: boot straps in 9..8, fallback in 6, area selects in 5..2,
  // busy in 1 and external wait mode in 0; bit 7 and the top bits read zero.
  assign status_word = {
    6'h00,
    boot_width_reg,
    1'b0,
    ~o_fallback_select_n,
    ~o_area_select_n,
    (state_reg != S_IDLE),
    ext_wait_reg
  };
  always @* begin
    rd_value = 16'h0000;
    if (area_space) begin
      case (area_field)
        `EACSD_AREA_BASE_OFS: rd_value = {8'h00, base_reg[area_idx]};
        `EACSD_AREA_MASK_OFS: rd_value = mask_reg[area_idx];
        `EACSD_AREA_CTRL_OFS: rd_value = ctrl_reg[area_idx];
        default: rd_value = 16'h0000;
      endcase
    end else if (hit_fallback) begin
      rd_value = fallback_ctrl_reg;
    end else if (hit_page_rom) begin
      rd_value = {13'h0000, page_rom_reg};
    end else if (hit_status) begin
      rd_value = status_word;
    end
  end

  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_reg_rdata <= 16'h0000;
    // Data are taken only on a read strobe, so they stand until the next read.
    end else if (i_ce && i_reg_rd) begin
      o_reg_rdata <= rd_value;
    end
  end

endmodule // eacsd_memory_controller
`default_nettype wire

//--- eacsd_mem_model.sv
`default_nettype none
// ****
// Memory that holds off each access for a set number of cycles.
// ****
module eacsd_mem_model (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_reset_n,
  // Controller side.
  input wire logic [4:0] i_sel_n,
  input wire logic i_rd_n,
  input wire logic i_wr_n,
  input wire logic [3:0] i_slow,
  output logic o_wait_n
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] cnt_reg;
  logic busy;
  assign busy = i_sel_n != 5'h1f && !(i_rd_n && i_wr_n);
  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cnt_reg <= 4'h0;
    end else begin
      cnt_reg <= busy ? cnt_reg + 4'h1 : 4'h0;
    end
  end
  // The wait line has a pull-up, so it reads high outside an access.
  assign o_wait_n = !(busy && cnt_reg < i_slow);
endmodule // eacsd_mem_model
`default_nettype wire

//--- eacsd_memory_controller_asserts.sv
`default_nettype none
// ****
// Access framing and chip select checks.
// ****
module eacsd_memory_controller_asserts (
  // Clock, reset and enable.
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_ce,
  // Watched bus ports.
  input wire logic i_bus_req,
  input wire logic i_bus_write,
  input wire logic i_int_io_hit,
  input wire logic i_int_mem_hit,
  input wire logic o_bus_ready,
  input wire logic [1:0] o_bus_width,
  input wire logic [3:0] o_area_select_n,
  input wire logic o_fallback_select_n,
  input wire logic o_rd_n,
  input wire logic o_wr_n
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  wire logic idle = o_rd_n && o_wr_n;
  wire logic hit = i_int_io_hit || i_int_mem_hit;
  wire logic take = i_ce && idle && i_bus_req;
  wire logic [4:0] sel_n = {o_fallback_select_n, o_area_select_n};
  property p_idle; idle |-> sel_n == 5'h1f; endproperty
  a_idle: assert property (p_idle) else $error("select low while idle");
  property p_one; $onehot0(~sel_n); endproperty
  a_one: assert property (p_one) else $error("two selects low");
  property p_hit; take && hit |=> idle && !o_bus_ready; endproperty
  a_hit: assert property (p_hit) else $error("internal hit went out");
  property p_rd; take && !hit && !i_bus_write |=> !o_rd_n && o_wr_n && sel_n != 5'h1f; endproperty
  a_rd: assert property (p_rd) else $error("read not started");
  property p_wr; take && !hit && i_bus_write |=> o_rd_n && !o_wr_n && sel_n != 5'h1f; endproperty
  a_wr: assert property (p_wr) else $error("write not started");
  property p_hold; !idle && !o_bus_ready |=> !idle && $stable(sel_n) && $stable(o_bus_width); endproperty
  a_hold: assert property (p_hold) else $error("access changed midway");
  property p_end; o_bus_ready |-> !idle ##1 idle; endproperty
  a_end: assert property (p_end) else $error("access not closed");
  property p_bound; $fell(idle) |-> ##[0:40] o_bus_ready; endproperty
  a_bound: assert property (p_bound) else $error("access never ends");
  c_hit: cover property (take && hit);
  c_fallback: cover property (o_bus_ready && !o_fallback_select_n);
  c_write: cover property (o_bus_ready && !o_wr_n);
endmodule // eacsd_memory_controller_asserts
bind eacsd_memory_controller eacsd_memory_controller_asserts u_chk (.i_clk, .i_reset_n, .i_ce,
  .i_bus_req, .i_bus_write, .i_int_io_hit, .i_int_mem_hit, .o_bus_ready, .o_bus_width,
  .o_area_select_n, .o_fallback_select_n, .o_rd_n, .o_wr_n);
`default_nettype wire

//--- tb.sv
`default_nettype none
// ****
// Register and external access sequences.
// ****
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic i_clk = 1'b0, i_reset_n = 1'b0, i_ce = 1'b1, i_reg_wr = 1'b0, i_reg_rd = 1'b0;
  logic i_bus_req = 1'b0, i_bus_write = 1'b0, i_int_io_hit = 1'b0, i_int_mem_hit = 1'b0;
  logic [4:0] i_reg_addr = 5'h00;
  logic [15:0] i_reg_wdata = 16'h0000;
  logic [1:0] i_boot_width_pins = 2'h2;
  logic [23:0] i_bus_addr = 24'h000000;
  logic [3:0] slow = 4'h3;
  wire logic [15:0] o_reg_rdata;
  wire logic [1:0] o_bus_width;
  wire logic [3:0] o_area_select_n;
  wire logic o_bus_ready, o_fallback_select_n, o_rd_n, o_wr_n, i_wait_n;
  int num_errors = 0, num_checks = 0;
  eacsd_memory_controller u_dut (.i_clk, .i_reset_n, .i_ce, .i_reg_addr, .i_reg_wdata,
    .i_reg_wr, .i_reg_rd, .o_reg_rdata, .i_boot_width_pins, .i_bus_req, .i_bus_write,
    .i_bus_addr, .i_int_io_hit, .i_int_mem_hit, .o_bus_ready, .o_bus_width, .i_wait_n,
    .o_area_select_n, .o_fallback_select_n, .o_rd_n, .o_wr_n);
  eacsd_mem_model u_mem (.i_clk, .i_reset_n,
    .i_sel_n({o_fallback_select_n, o_area_select_n}), .i_rd_n(o_rd_n), .i_wr_n(o_wr_n),
    .i_slow(slow), .o_wait_n(i_wait_n));
  task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic wreg(input logic [4:0] a, input logic [15:0] d);
    @(posedge i_clk);
    i_reg_wr <= 1'b1;
    i_reg_addr <= a;
    i_reg_wdata <= d;
    @(posedge i_clk);
    i_reg_wr <= 1'b0;
  endtask
  task automatic rreg(input logic [4:0] a, input logic [15:0] e);
    @(posedge i_clk);
    i_reg_rd <= 1'b1;
    i_reg_addr <= a;
    @(posedge i_clk);
    i_reg_rd <= 1'b0;
    #1;
    chk("rdata", o_reg_rdata, e);
  endtask
  // The request is held until the ready cycle has been sampled.
  task automatic acc(input logic w, input logic [23:0] a, input logic [4:0] s,
      input logic [1:0] wd, input logic [23:0] n);
    logic [23:0] k;
    @(posedge i_clk);
    i_bus_req <= 1'b1;
    i_bus_write <= w;
    i_bus_addr <= a;
    k = 24'h0;
    do begin
      @(posedge i_clk);
      #1;
      k = k + 24'h1;
    end while (o_bus_ready !== 1'b1 && k < 24'h40);
    chk("cycles", k, n);
    chk("select", {o_fallback_select_n, o_area_select_n}, s);
    chk("width", o_bus_width, wd);
    @(posedge i_clk);
    i_bus_req <= 1'b0;
    if (k == 24'h40) begin
      wrap_up();
    end
  endtask
  initial begin
    forever #20 i_clk = ~i_clk;
  end
  initial begin
    repeat (20) @(posedge i_clk);
    i_reset_n <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_boot_width_pins <= 2'h1;
    rreg(5'h0a, 16'h8200);
    rreg(5'h12, 16'h0200);
    rreg(5'h02, 16'h0000);
    rreg(5'h10, 16'h0000);
    rreg(5'h13, 16'h0000);
    acc(1'b0, 24'hfedcba, 5'h1b, 2'h2, 24'h1);
    wreg(5'h04, 16'h0011);
    wreg(5'h05, 16'h0001);
    acc(1'b0, 24'h110000, 5'h1b, 2'h2, 24'h1);
    wreg(5'h06, 16'h8121);
    acc(1'b0, 24'h1101ff, 5'h1d, 2'h1, 24'h3);
    acc(1'b1, 24'h110100, 5'h1d, 2'h1, 24'h2);
    acc(1'b0, 24'h110200, 5'h1b, 2'h2, 24'h1);
    wreg(5'h05, 16'h0002);
    wreg(5'h06, 16'h8121);
    acc(1'b0, 24'h11fe00, 5'h1d, 2'h1, 24'h3);
    acc(1'b0, 24'h11ff00, 5'h1b, 2'h2, 24'h1);
    wreg(5'h00, 16'h0011);
    wreg(5'h01, 16'h0000);
    wreg(5'h02, 16'h8003);
    acc(1'b1, 24'h110000, 5'h1e, 2'h0, 24'h4);
    acc(1'b0, 24'h110000, 5'h1e, 2'h0, 24'h1);
    wreg(5'h08, 16'h0080);
    wreg(5'h09, 16'h0000);
    wreg(5'h10, 16'h0044);
    wreg(5'h0a, 16'hc100);
    acc(1'b0, 24'h807fff, 5'h1b, 2'h1, 24'h1);
    acc(1'b0, 24'h808000, 5'h0f, 2'h0, 24'h4);
    acc(1'b1, 24'h808000, 5'h0f, 2'h0, 24'h4);
    slow <= 4'h0;
    acc(1'b0, 24'h808000, 5'h0f, 2'h0, 24'h1);
    wreg(5'h0c, 16'h0000);
    wreg(5'h0d, 16'h00ff);
    wreg(5'h0e, 16'h8200);
    acc(1'b0, 24'h7f0000, 5'h17, 2'h2, 24'h1);
    wreg(5'h11, 16'h0005);
    rreg(5'h11, 16'h0005);
    acc(1'b0, 24'h11fe00, 5'h1d, 2'h1, 24'h3);
    acc(1'b0, 24'h11fe08, 5'h1d, 2'h1, 24'h1);
    acc(1'b0, 24'h11fe10, 5'h1d, 2'h1, 24'h3);
    i_ce <= 1'b0;
    wreg(5'h0c, 16'h0011);
    i_ce <= 1'b1;
    rreg(5'h0c, 16'h0000);
    for (int io = 0; io < 2; io++) begin
      @(posedge i_clk);
      i_bus_req <= 1'b1;
      i_int_io_hit <= io[0];
      i_int_mem_hit <= !io[0];
      repeat (3) begin
        @(posedge i_clk);
        #1;
        chk("ignored", {o_bus_ready, o_fallback_select_n, o_area_select_n}, 24'h1f);
      end
      @(posedge i_clk);
      i_bus_req <= 1'b0;
      i_int_io_hit <= 1'b0;
      i_int_mem_hit <= 1'b0;
    end
    i_reset_n <= 1'b0;
    repeat (3) @(posedge i_clk);
    i_reset_n <= 1'b1;
    repeat (2) @(posedge i_clk);
    rreg(5'h0a, 16'h8100);
    rreg(5'h12, 16'h0100);
    rreg(5'h06, 16'h0000);
    acc(1'b0, 24'h110000, 5'h1b, 2'h1, 24'h1);
    wrap_up();
  end
endmodule // tb
`default_nettype wire
